// ---- logic/ccsrb_pkg.sv ----
// Package of addresses, field positions and encodings for the core custom CSR bank
package ccsrb_pkg;

	// ************************************************************
	// CSR addresses (12-bit CSR index space)
	// ************************************************************
	localparam logic [11:0] CCSRB_ADDR_EVT_REQ   = 12'h811;
	localparam logic [11:0] CCSRB_ADDR_WAKE_SEL  = 12'h810;
	localparam logic [11:0] CCSRB_ADDR_SAT_FLAG  = 12'h801;
	localparam logic [11:0] CCSRB_ADDR_FEATURE   = 12'hFC2;
	localparam logic [11:0] CCSRB_ADDR_ISIDE     = 12'hFC0;
	localparam logic [11:0] CCSRB_ADDR_DSIDE     = 12'hFC1;
	localparam logic [11:0] CCSRB_ADDR_XLAT      = 12'hFC3;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CCSRB_BIT_CTRL          = 0;
	localparam int CCSRB_FEAT_OPT_HI       = 11;
	localparam int CCSRB_FEAT_TIER1        = 12;
	localparam int CCSRB_FEAT_TIER3        = 14;
	localparam int CCSRB_FEAT_COMPR        = 15;
	localparam int CCSRB_FEAT_PRIV_REGION  = 16;
	localparam int CCSRB_FEAT_VDP_LO       = 17;
	localparam int CCSRB_FEAT_VDP_HI       = 18;
	localparam int CCSRB_FEAT_WGUARD       = 19;
	localparam int CCSRB_FEAT_TRACE        = 20;
	localparam int CCSRB_FEAT_RED_LO       = 21;
	localparam int CCSRB_FEAT_RED_HI       = 22;
	localparam int CCSRB_FEAT_VCOPROC      = 23;
	localparam int CCSRB_FEAT_CUSTOM_N     = 24;
	localparam int CCSRB_MEM_SIZE_LO       = 16;
	localparam int CCSRB_MEM_SIZE_HI       = 20;
	localparam int CCSRB_ISIDE_XONLY       = 21;
	localparam int CCSRB_ISIDE_MEM_ECC     = 22;
	localparam int CCSRB_DSIDE_MEM_ECC     = 21;
	localparam int CCSRB_CACHE_ECC         = 10;
	localparam int CCSRB_LINE_LO           = 7;
	localparam int CCSRB_LINE_HI           = 9;
	localparam int CCSRB_WAY_LO            = 4;
	localparam int CCSRB_WAY_HI            = 6;
	localparam int CCSRB_SET_LO            = 0;
	localparam int CCSRB_SET_HI            = 3;
	localparam int CCSRB_XLAT_I_LO         = 16;
	localparam int CCSRB_XLAT_I_HI         = 18;
	localparam int CCSRB_XLAT_D_LO         = 19;
	localparam int CCSRB_XLAT_D_HI         = 21;
	localparam int CCSRB_XLAT_NAPOT        = 11;
	localparam int CCSRB_XLAT_ECC          = 10;

	// ************************************************************
	// Encoding limits and reset values
	// ************************************************************
	localparam logic [4:0]  CCSRB_MEM_SIZE_MAX  = 5'h16;
	localparam logic [2:0]  CCSRB_LINE_MAX      = 3'h5;
	localparam logic [3:0]  CCSRB_SET_MAX       = 4'hA;
	localparam logic [2:0]  CCSRB_XLAT_MIN      = 3'h4;
	localparam logic [1:0]  CCSRB_VDP_MAX       = 2'h1;
	localparam logic [31:0] CCSRB_CTRL_RESET    = 32'h0000_0000;

	// Redundancy scheme codes
	typedef enum logic [1:0] {
		CCSRB_RED_NONE  = 2'h0,
		CCSRB_RED_LOCK  = 2'h1,
		CCSRB_RED_SPLIT = 2'h2,
		CCSRB_RED_GRADE = 2'h3
	} ccsrb_red_type;

endpackage : ccsrb_pkg

// ---- logic/ccsrb_cache_geom.sv ----
// Geometry field packer for one cache or translation buffer description
`timescale 1ns/1ps
`default_nettype none
module ccsrb_cache_geom
	import ccsrb_pkg::*;
#(
	parameter logic       ECC_PRESENT = 1'b0,
	parameter logic [2:0] LINE_CODE   = 3'h0,
	parameter logic [2:0] ASSOC_CODE  = 3'h0,
	parameter logic [3:0] INDEX_CODE  = 4'h0,
	parameter bit         HAS_LINE    = 1'b1
) (
	output wire logic [10:0] geom_o
);

	// ************************************************************
	// Configuration checks
	// ************************************************************
	initial begin
		if (LINE_CODE > CCSRB_LINE_MAX) begin
			$error("line size code out of range");
		end
		if (INDEX_CODE > CCSRB_SET_MAX) begin
			$error("set count code out of range");
		end
	end

	// ************************************************************
	// Packing
	// ************************************************************
	// Line bits stay zero for the translation buffer layout
	assign geom_o[CCSRB_CACHE_ECC]                 = ECC_PRESENT;
	assign geom_o[CCSRB_LINE_HI:CCSRB_LINE_LO]     = HAS_LINE ? LINE_CODE : 3'h0; // R17 R19
	assign geom_o[CCSRB_WAY_HI:CCSRB_WAY_LO]       = ASSOC_CODE;                  // R17 R22
	assign geom_o[CCSRB_SET_HI:CCSRB_SET_LO]       = INDEX_CODE;                  // R17 R22

endmodule : ccsrb_cache_geom
`default_nettype wire

// ---- logic/ccsrb_core_csr_bank.sv ----
// Core custom CSR bank: event pulse, wake select, saturation flag, configuration words
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) Writing one to event request pulses event output one cycle, then self-clears.
// (R2) Wake select zero: sleeping core wakes on interrupt or NMI.
// (R3) Wake select one: sleeping core wakes on event or NMI, not interrupts.
// (R4) Packed-SIMD overflow sets sticky saturation flag bit 0 until cleared.
// (R5) Software writing zero to saturation flag register clears it.
// (R6) Saturation flag register exists only with packed-SIMD support built in.
// (R7) Feature bits 0..11 report the twelve build options in documented order.
// (R8) Feature bit 24 reads zero when custom compressed supported; needs bit 15.
// (R9) Feature bits 22:21 encode the redundancy scheme.
// (R10) Feature bits 18:17 give vector datapath ratio; codes above one reserved.
// (R11) Feature bit 16 reads one when private peripherals share one region.
// (R12) Feature bits 14..12 report packed-SIMD tiers 3..1 when SIMD built.
// (R13) Feature bits 23, 20, 19: vector coprocessor, trace unit, world guard.
// (R14) Instruction memory size at 20:16: zero absent, 1..22 power-of-two sizes.
// (R15) Instruction side bit 21 flags execute-only memory; loads and stores denied.
// (R16) Instruction side bit 22 memory ECC, bit 10 I-cache ECC.
// (R17) I-cache line, ways and sets fields use documented codes.
// (R18) Data side: memory ECC bit 21, size 20:16, D-cache ECC bit 10.
// (R19) D-cache geometry uses the I-cache encodings.
// (R20) Translation buffer sizes: zero absent, 4..7 give 8..64 entries.
// (R21) Translation word: NAPOT bit 11, main buffer ECC bit 10.
// (R22) Main translation buffer ways 6:4 and entries per way 3:0 encoded.
// (R23) Reserved bits read zero; writes to information words are ignored.
module ccsrb_core_csr_bank
	import ccsrb_pkg::*;
#(
	parameter logic [11:0] FEAT_OPTIONS     = 12'h000,
	parameter bit          SIMD_BUILT       = 1'b1,
	parameter logic [2:0]  SIMD_TIERS       = 3'h0,
	parameter bit          COMPR_EXT        = 1'b0,
	parameter bit          CUSTOM_COMPR     = 1'b0,
	parameter bit          PRIV_REGION      = 1'b1,
	parameter logic [1:0]  VDP_RATIO        = 2'h0,
	parameter bit          WGUARD           = 1'b0,
	parameter bit          TRACE_UNIT       = 1'b0,
	parameter logic [1:0]  RED_SCHEME       = CCSRB_RED_NONE,
	parameter bit          VCOPROC          = 1'b0,
	parameter bit          IMEM_ECC         = 1'b0,
	parameter bit          IMEM_XONLY       = 1'b0,
	parameter logic [4:0]  IMEM_SIZE        = 5'h0,
	parameter bit          ICACHE_ECC_PRESENT           = 1'b0,
	parameter logic [2:0]  IC_LINE          = 3'h0,
	parameter logic [2:0]  IC_ASSOC         = 3'h0,
	parameter logic [3:0]  IC_INDEX         = 4'h0,
	parameter bit          DMEM_ECC         = 1'b0,
	parameter logic [4:0]  DMEM_SIZE        = 5'h0,
	parameter bit          DCACHE_ECC_PRESENT           = 1'b0,
	parameter logic [2:0]  DC_LINE          = 3'h0,
	parameter logic [2:0]  DC_ASSOC         = 3'h0,
	parameter logic [3:0]  DC_INDEX         = 4'h0,
	parameter logic [2:0]  DXLAT_CODE       = 3'h0,
	parameter logic [2:0]  IXLAT_CODE       = 3'h0,
	parameter bit          XLAT_NAPOT       = 1'b0,
	parameter bit          XLAT_ECC         = 1'b0,
	parameter logic [2:0]  XLAT_ASSOC       = 3'h0,
	parameter logic [3:0]  XLAT_INDEX       = 4'h0
) (
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        csr_wr_i,
	input  wire logic        csr_rd_i,
	input  wire logic [11:0] csr_addr_i,
	input  wire logic [31:0] csr_wdata_i,
	input  wire logic        simd_overflow_i,
	input  wire logic        sleeping_i,
	input  wire logic        irq_i,
	input  wire logic        nmi_i,
	input  wire logic        event_i,
	output var  logic [31:0] csr_rdata_o,
	output var  logic        csr_hit_o,
	output var  logic        event_pulse_o,
	output var  logic        wake_o,
	output var  logic        imem_data_deny_o
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	initial begin
		if (IMEM_SIZE > CCSRB_MEM_SIZE_MAX || DMEM_SIZE > CCSRB_MEM_SIZE_MAX) begin
			$error("local memory size code out of range");
		end
		if (VDP_RATIO > CCSRB_VDP_MAX) begin
			$error("vector datapath ratio code reserved");
		end
		if ((DXLAT_CODE != 3'h0 && DXLAT_CODE < CCSRB_XLAT_MIN) ||
		    (IXLAT_CODE != 3'h0 && IXLAT_CODE < CCSRB_XLAT_MIN)) begin
			$error("translation buffer size code reserved");
		end
	end

	// ************************************************************
	// Synchronisers for asynchronous wake sources
	// ************************************************************
	// Three stages; a change counts once stages two and three agree
	logic [2:0] irq_sync_r;
	logic [2:0] nmi_sync_r;
	logic [2:0] evt_sync_r;
	logic       irq_lvl_r;
	logic       nmi_lvl_r;
	logic       evt_lvl_r;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			irq_sync_r <= 3'h0;
			nmi_sync_r <= 3'h0;
			evt_sync_r <= 3'h0;
		end else begin
			irq_sync_r <= {irq_sync_r[1:0], irq_i};
			nmi_sync_r <= {nmi_sync_r[1:0], nmi_i};
			evt_sync_r <= {evt_sync_r[1:0], event_i};
		end
	end

	// Filtered levels only move when the last two stages agree
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			irq_lvl_r <= 1'b0;
			nmi_lvl_r <= 1'b0;
			evt_lvl_r <= 1'b0;
		end else begin
			if (irq_sync_r[2] == irq_sync_r[1]) begin
				irq_lvl_r <= irq_sync_r[2];
			end
			if (nmi_sync_r[2] == nmi_sync_r[1]) begin
				nmi_lvl_r <= nmi_sync_r[2];
			end
			if (evt_sync_r[2] == evt_sync_r[1]) begin
				evt_lvl_r <= evt_sync_r[2];
			end
		end
	end

	// ************************************************************
	// Write decode
	// ************************************************************
	logic wr_evt;
	logic wr_wake;
	logic wr_sat;

	assign wr_evt  = csr_wr_i && (csr_addr_i == CCSRB_ADDR_EVT_REQ);
	assign wr_wake = csr_wr_i && (csr_addr_i == CCSRB_ADDR_WAKE_SEL);
	assign wr_sat  = csr_wr_i && SIMD_BUILT && (csr_addr_i == CCSRB_ADDR_SAT_FLAG); // R6

	// ************************************************************
	// Event pulse request
	// ************************************************************
	// The stored bit is the pulse itself, so it lives one cycle per requesting write
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			event_pulse_o <= 1'b0;
		end else begin
			event_pulse_o <= wr_evt && csr_wdata_i[CCSRB_BIT_CTRL]; // R1
		end
	end

	// ************************************************************
	// Wake source select
	// ************************************************************
	logic wake_sel_r;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wake_sel_r <= CCSRB_CTRL_RESET[CCSRB_BIT_CTRL];
		end else if (wr_wake) begin
			wake_sel_r <= csr_wdata_i[CCSRB_BIT_CTRL];
		end
	end

	// NMI wakes a sleeping core under either select; the select picks interrupts or events
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wake_o <= 1'b0;
		end else if (!wake_sel_r) begin
			wake_o <= sleeping_i && (irq_lvl_r || nmi_lvl_r); // R2
		end else begin
			wake_o <= sleeping_i && (evt_lvl_r || nmi_lvl_r); // R3
		end
	end

	// ************************************************************
	// Saturation sticky flag
	// ************************************************************
	// Overflow wins over a clearing write in the same cycle
	logic sat_r;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sat_r <= 1'b0;
		end else if (SIMD_BUILT && simd_overflow_i) begin
			sat_r <= 1'b1; // R4
		end else if (wr_sat && !csr_wdata_i[CCSRB_BIT_CTRL]) begin
			sat_r <= 1'b0; // R5
		end
	end

	// ************************************************************
	// Execute-only instruction memory guard
	// ************************************************************
	// Held as a register so the guard reaches the load/store unit glitch-free
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			imem_data_deny_o <= 1'b0;
		end else begin
			imem_data_deny_o <= IMEM_XONLY; // R15
		end
	end

	// ************************************************************
	// Configuration words
	// ************************************************************
	logic [31:0] feat_word;
	logic [31:0] iside_word;
	logic [31:0] dside_word;
	logic [31:0] xlat_word;
	logic [10:0] ic_geom;
	logic [10:0] dc_geom;
	logic [10:0] tl_geom;

	ccsrb_cache_geom #(
		.ECC_PRESENT (ICACHE_ECC_PRESENT),
		.LINE_CODE   (IC_LINE),
		.ASSOC_CODE  (IC_ASSOC),
		.INDEX_CODE  (IC_INDEX),
		.HAS_LINE    (1'b1)
	) u_ic_geom (
		.geom_o (ic_geom)
	);

	ccsrb_cache_geom #(
		.ECC_PRESENT (DCACHE_ECC_PRESENT),
		.LINE_CODE   (DC_LINE),
		.ASSOC_CODE  (DC_ASSOC),
		.INDEX_CODE  (DC_INDEX),
		.HAS_LINE    (1'b1)
	) u_dc_geom (
		.geom_o (dc_geom)
	);

	ccsrb_cache_geom #(
		.ECC_PRESENT (XLAT_ECC),
		.LINE_CODE   (3'h0),
		.ASSOC_CODE  (XLAT_ASSOC),
		.INDEX_CODE  (XLAT_INDEX),
		.HAS_LINE    (1'b0)
	) u_tl_geom (
		.geom_o (tl_geom)
	);

	// Reserved bits start at zero and stay so
	always_comb begin
		feat_word = 32'h0000_0000; // R23
		feat_word[CCSRB_FEAT_OPT_HI:0] = FEAT_OPTIONS; // R7
		feat_word[CCSRB_FEAT_TIER3:CCSRB_FEAT_TIER1] = SIMD_BUILT ? SIMD_TIERS : 3'h0; // R12
		feat_word[CCSRB_FEAT_COMPR] = COMPR_EXT;
		feat_word[CCSRB_FEAT_PRIV_REGION] = PRIV_REGION; // R11
		feat_word[CCSRB_FEAT_VDP_HI:CCSRB_FEAT_VDP_LO] = VDP_RATIO; // R10
		feat_word[CCSRB_FEAT_WGUARD] = WGUARD; // R13
		feat_word[CCSRB_FEAT_TRACE] = TRACE_UNIT; // R13
		feat_word[CCSRB_FEAT_RED_HI:CCSRB_FEAT_RED_LO] = RED_SCHEME; // R9
		feat_word[CCSRB_FEAT_VCOPROC] = VCOPROC; // R13
		// Inverted sense, only meaningful with the compressed bit set
		feat_word[CCSRB_FEAT_CUSTOM_N] = COMPR_EXT && !CUSTOM_COMPR; // R8
	end

	always_comb begin
		iside_word = 32'h0000_0000;
		iside_word[CCSRB_ISIDE_MEM_ECC] = IMEM_ECC; // R16
		iside_word[CCSRB_ISIDE_XONLY] = IMEM_XONLY; // R15
		iside_word[CCSRB_MEM_SIZE_HI:CCSRB_MEM_SIZE_LO] = IMEM_SIZE; // R14
		iside_word[CCSRB_CACHE_ECC:0] = ic_geom; // R16 R17
	end

	always_comb begin
		dside_word = 32'h0000_0000;
		dside_word[CCSRB_DSIDE_MEM_ECC] = DMEM_ECC; // R18
		dside_word[CCSRB_MEM_SIZE_HI:CCSRB_MEM_SIZE_LO] = DMEM_SIZE; // R18
		dside_word[CCSRB_CACHE_ECC:0] = dc_geom; // R18 R19
	end

	always_comb begin
		xlat_word = 32'h0000_0000;
		xlat_word[CCSRB_XLAT_D_HI:CCSRB_XLAT_D_LO] = DXLAT_CODE; // R20
		xlat_word[CCSRB_XLAT_I_HI:CCSRB_XLAT_I_LO] = IXLAT_CODE; // R20
		xlat_word[CCSRB_XLAT_NAPOT] = XLAT_NAPOT; // R21
		xlat_word[CCSRB_CACHE_ECC:0] = tl_geom; // R21 R22
	end

	// ************************************************************
	// Read path
	// ************************************************************
	// Registered read: data and hit appear the cycle after csr_rd_i
	logic [31:0] rdata_nxt;
	logic        hit_nxt;

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		hit_nxt   = 1'b1;
		if (csr_addr_i == CCSRB_ADDR_EVT_REQ) begin
			rdata_nxt = 32'h0000_0000; // R1
		end else if (csr_addr_i == CCSRB_ADDR_WAKE_SEL) begin
			rdata_nxt[CCSRB_BIT_CTRL] = wake_sel_r;
		end else if (csr_addr_i == CCSRB_ADDR_SAT_FLAG && SIMD_BUILT) begin
			rdata_nxt[CCSRB_BIT_CTRL] = sat_r; // R6
		end else if (csr_addr_i == CCSRB_ADDR_FEATURE) begin
			rdata_nxt = feat_word;
		end else if (csr_addr_i == CCSRB_ADDR_ISIDE) begin
			rdata_nxt = iside_word;
		end else if (csr_addr_i == CCSRB_ADDR_DSIDE) begin
			rdata_nxt = dside_word;
		end else if (csr_addr_i == CCSRB_ADDR_XLAT) begin
			rdata_nxt = xlat_word;
		end else begin
			hit_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			csr_rdata_o <= 32'h0000_0000;
			csr_hit_o   <= 1'b0;
		end else begin
			csr_rdata_o <= csr_rd_i ? rdata_nxt : 32'h0000_0000;
			csr_hit_o   <= (csr_rd_i || csr_wr_i) && hit_nxt;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_evt_pulse;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(wr_evt && csr_wdata_i[0]) |=>
			event_pulse_o ##1 (!event_pulse_o || $past(wr_evt && csr_wdata_i[0], 1));
	endproperty
	a_evt_pulse: assert property (p_evt_pulse) else $error("event pulse not one cycle"); // R1

	property p_evt_zero;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(!wr_evt || !csr_wdata_i[0]) |=> !event_pulse_o;
	endproperty
	a_evt_zero: assert property (p_evt_zero) else $error("event pulse without request"); // R1

	property p_wake_irq;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(!wake_sel_r && sleeping_i && irq_lvl_r) |=> wake_o;
	endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("interrupt did not wake"); // R2

	property p_wake_evt;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(wake_sel_r && sleeping_i && !evt_lvl_r && !nmi_lvl_r) |=> !wake_o;
	endproperty
	a_wake_evt: assert property (p_wake_evt) else $error("woke without event in event mode"); // R3

	property p_sat_set;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(SIMD_BUILT && simd_overflow_i) |=> sat_r;
	endproperty
	a_sat_set: assert property (p_sat_set) else $error("overflow not recorded"); // R4

	property p_sat_hold;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(sat_r && !wr_sat) |=> sat_r;
	endproperty
	a_sat_hold: assert property (p_sat_hold) else $error("sticky flag lost"); // R4

	property p_sat_clr;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(wr_sat && !csr_wdata_i[0] && !simd_overflow_i) |=> !sat_r;
	endproperty
	a_sat_clr: assert property (p_sat_clr) else $error("flag not cleared"); // R5

	property p_feat_rd;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(csr_rd_i && csr_addr_i == CCSRB_ADDR_FEATURE) |=>
			csr_hit_o && csr_rdata_o[31:25] == 7'h0 && csr_rdata_o[11:0] == FEAT_OPTIONS;
	endproperty
	a_feat_rd: assert property (p_feat_rd) else $error("feature word wrong"); // R7 R23

	property p_iside_rd;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(csr_rd_i && csr_addr_i == CCSRB_ADDR_ISIDE) |=>
			csr_rdata_o[20:16] == IMEM_SIZE && csr_rdata_o[15:11] == 5'h0;
	endproperty
	a_iside_rd: assert property (p_iside_rd) else $error("instruction side word wrong"); // R14

	c_evt: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) event_pulse_o);
	c_wake: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) wake_sel_r && wake_o);
	c_sat: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) sat_r ##1 !sat_r);

endmodule : ccsrb_core_csr_bank
`default_nettype wire

// ---- dv/ccsrb_soc_partner.sv ----
// Behavioural model of the SoC event logic and wake sources beside the core
`timescale 1ns/1ps
`default_nettype none
module ccsrb_soc_partner (
	input  wire logic sys_clk_i,
	input  wire logic event_pulse_i,
	output var  logic irq_o,
	output var  logic nmi_o,
	output var  logic event_o,
	output var  int   event_count_o
);
	// ************************************************************
	// Wake sources
	// ************************************************************
	// Lines move 3 ns after the caller's edge, so they land unrelated to the core clock
	task automatic set_lines(input logic irq, input logic nmi, input logic evt);
		#3;
		irq_o   = irq;
		nmi_o   = nmi;
		event_o = evt;
	endtask : set_lines

	// Quiet lines from 3 ns, once the task's own delay has passed
	initial begin
		set_lines(1'h0, 1'h0, 1'h0);
	end

	// ************************************************************
	// Event receiver
	// ************************************************************
	// Counts every cycle the core holds its event output, so a stretched pulse shows
	// Two-state counter starts at zero, so one process alone drives it
	always @(posedge sys_clk_i) begin
		if (event_pulse_i === 1'h1) begin
			event_count_o <= event_count_o + 1;
		end
	end
endmodule : ccsrb_soc_partner
`default_nettype wire

// ---- dv/ccsrb_core_csr_bank_bench.sv ----
// Self-checking bench for the core custom CSR bank
`timescale 1ns/1ps
`default_nettype none
module ccsrb_core_csr_bank_bench import ccsrb_pkg::*; ();
	typedef struct packed { logic [11:0] addr; logic [31:0] data; logic hit; } ccsrb_row_type;
	logic        sys_clk_i;
	logic        sys_rst_i;
	logic        csr_wr, csr_rd, simd_ovf, sleeping, irq, nmi, evt;
	logic [11:0] csr_addr;
	logic [31:0] csr_wdata, rdata, rdata_b;
	logic        hit, hit_b, pulse, wake, deny;
	int          mismatches, comparisons, evt_count;
	// Build under test: multi-bit fields of one word hold distinct codes, except DSIZE and DLINE, both 1
	localparam logic [11:0] OPTS  = 12'hA5C;
	localparam logic [4:0]  ISIZE = 5'h16, DSIZE = 5'h01;
	localparam logic [3:0]  ISET  = 4'hA, TSET = 4'h9;
	localparam logic [2:0]  TIERS = 3'h5, ILINE = 3'h5, IWAY = 3'h3, DLINE = 3'h1;
	localparam logic [2:0]  DWAY  = 3'h7, DXL = 3'h7, IXL = 3'h4, TWAY = 3'h2;
	localparam logic [1:0]  VDP   = 2'h1;
	localparam bit          ON    = 1'h1, OFF = 1'h0;
	// Expected words built field by field from the parameters given below
	localparam ccsrb_row_type ROWS [8] = '{
		'{CCSRB_ADDR_FEATURE, {7'h00, 1'h0, 1'h1, 2'h2, 1'h0, 1'h1, 2'h1, 1'h1, 1'h1, 3'h5,
			12'hA5C}, 1'h1},
		'{CCSRB_ADDR_ISIDE, {9'h000, 1'h1, 1'h1, 5'h16, 5'h00, 1'h0, 3'h5, 3'h3, 4'hA}, 1'h1},
		'{CCSRB_ADDR_DSIDE, {10'h000, 1'h1, 5'h01, 5'h00, 1'h1, 3'h1, 3'h7, 4'h0}, 1'h1},
		'{CCSRB_ADDR_XLAT, {10'h000, 3'h7, 3'h4, 4'h0, 1'h1, 1'h0, 3'h0, 3'h2, 4'h9}, 1'h1},
		'{CCSRB_ADDR_EVT_REQ, 32'h0, 1'h1}, '{CCSRB_ADDR_WAKE_SEL, 32'h0, 1'h1},
		'{CCSRB_ADDR_SAT_FLAG, 32'h0, 1'h1}, '{12'h7FF, 32'h0, 1'h0}};

	// ************************************************************
	// Design, reduced build and partner
	// ************************************************************
	ccsrb_core_csr_bank #(.FEAT_OPTIONS(OPTS), .SIMD_TIERS(TIERS), .COMPR_EXT(ON),
		.CUSTOM_COMPR(ON), .VDP_RATIO(VDP), .WGUARD(ON), .RED_SCHEME(CCSRB_RED_SPLIT),
		.VCOPROC(ON), .IMEM_ECC(ON), .IMEM_XONLY(ON), .IMEM_SIZE(ISIZE), .IC_LINE(ILINE),
		.IC_ASSOC(IWAY), .IC_INDEX(ISET), .DMEM_ECC(ON), .DMEM_SIZE(DSIZE), .DCACHE_ECC_PRESENT(ON),
		.DC_LINE(DLINE), .DC_ASSOC(DWAY), .DXLAT_CODE(DXL), .IXLAT_CODE(IXL),
		.XLAT_NAPOT(ON), .XLAT_ASSOC(TWAY), .XLAT_INDEX(TSET)) dut (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .csr_wr_i(csr_wr), .csr_rd_i(csr_rd),
		.csr_addr_i(csr_addr), .csr_wdata_i(csr_wdata), .simd_overflow_i(simd_ovf),
		.sleeping_i(sleeping), .irq_i(irq), .nmi_i(nmi), .event_i(evt), .csr_rdata_o(rdata),
		.csr_hit_o(hit), .event_pulse_o(pulse), .wake_o(wake), .imem_data_deny_o(deny));
	// Same bus without packed-SIMD support, so the flag register must vanish
	ccsrb_core_csr_bank #(.SIMD_BUILT(OFF)) dut_nosimd (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .csr_wr_i(csr_wr), .csr_rd_i(csr_rd),
		.csr_addr_i(csr_addr), .csr_wdata_i(csr_wdata), .simd_overflow_i(simd_ovf),
		.sleeping_i(sleeping), .irq_i(irq), .nmi_i(nmi), .event_i(evt), .csr_rdata_o(rdata_b),
		.csr_hit_o(hit_b), .event_pulse_o(), .wake_o(), .imem_data_deny_o());
	ccsrb_soc_partner partner (.sys_clk_i(sys_clk_i), .event_pulse_i(pulse), .irq_o(irq),
		.nmi_o(nmi), .event_o(evt), .event_count_o(evt_count));

	// ************************************************************
	// Tasks
	// ************************************************************
	// Strobes change only at the falling edge, one bus cycle per call
	task automatic drive(input logic w, input logic r, input logic [11:0] a,
		input logic [31:0] d);
		@(negedge sys_clk_i);
		csr_wr    = w;
		csr_rd    = r;
		csr_addr  = a;
		csr_wdata = d;
	endtask : drive
	// Returns one edge after the strobe was taken, while the answer stands
	task automatic csr_write(input logic [11:0] a, input logic [31:0] d);
		drive(1'h1, 1'h0, a, d);
		drive(1'h0, 1'h0, a, 32'h0);
	endtask : csr_write
	task automatic csr_read(input logic [11:0] a);
		drive(1'h0, 1'h1, a, 32'h0);
		drive(1'h0, 1'h0, a, 32'h0);
	endtask : csr_read
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			mismatches++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask : check
	task automatic conclude();
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	// ************************************************************
	// Clock, watchdog and main sequence
	// ************************************************************
	initial begin
		sys_clk_i = 1'h0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// Whole sequence needs well under a thousand cycles
	initial begin
		#(20 * 5000);
		mismatches++;
		conclude();
	end
	initial begin
		mismatches = 0;
		comparisons = 0;
		{sys_rst_i, csr_wr, csr_rd, simd_ovf, sleeping} = 5'h10;
		csr_addr = 12'h000;
		csr_wdata = 32'h0;
		repeat (3) @(negedge sys_clk_i);
		check({28'h0, pulse, wake, hit, deny}, 32'h0);
		sys_rst_i = 1'h0;
		@(negedge sys_clk_i);
		check({31'h0, deny}, 32'h1);
		// Table pass, then again after writing ones to the information words
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 8; i++) begin
				if (p == 1 && i < 4) begin
					csr_write(ROWS[i].addr, 32'hFFFF_FFFF);
					check({31'h0, hit}, 32'h1);
				end
				csr_read(ROWS[i].addr);
				check(rdata, ROWS[i].data);
				check({31'h0, hit}, {31'h0, ROWS[i].hit});
			end
		end
		// Reduced build: flag register unmapped, tier bits clear
		csr_read(CCSRB_ADDR_SAT_FLAG);
		check({rdata_b[30:0], hit_b}, 32'h0);
		csr_read(CCSRB_ADDR_FEATURE);
		check(rdata_b, 32'h0001_0000);
		// Single event, a zero write, then two back to back
		csr_write(CCSRB_ADDR_EVT_REQ, 32'h1);
		check({31'h0, pulse}, 32'h1);
		csr_write(CCSRB_ADDR_EVT_REQ, 32'h0);
		check({31'h0, pulse}, 32'h0);
		drive(1'h1, 1'h0, CCSRB_ADDR_EVT_REQ, 32'h1);
		drive(1'h1, 1'h0, CCSRB_ADDR_EVT_REQ, 32'h1);
		drive(1'h0, 1'h0, CCSRB_ADDR_EVT_REQ, 32'h0);
		check({31'h0, pulse}, 32'h1);
		@(negedge sys_clk_i);
		check({31'h0, pulse}, 32'h0);
		check(32'(evt_count), 32'h3);
		// Sticky flag: set, survives a one write, overflow beats a clear
		simd_ovf = 1'h1;
		@(negedge sys_clk_i);
		simd_ovf = 1'h0;
		csr_write(CCSRB_ADDR_SAT_FLAG, 32'h1);
		csr_read(CCSRB_ADDR_SAT_FLAG);
		check(rdata, 32'h1);
		drive(1'h1, 1'h0, CCSRB_ADDR_SAT_FLAG, 32'h0);
		simd_ovf = 1'h1;
		drive(1'h0, 1'h0, CCSRB_ADDR_SAT_FLAG, 32'h0);
		simd_ovf = 1'h0;
		csr_read(CCSRB_ADDR_SAT_FLAG);
		check(rdata, 32'h1);
		csr_write(CCSRB_ADDR_SAT_FLAG, 32'h0);
		csr_read(CCSRB_ADDR_SAT_FLAG);
		check(rdata, 32'h0);
		// Each wake source under each select value, five cycles of sync latency
		sleeping = 1'h1;
		for (int s = 0; s < 2; s++) begin
			csr_write(CCSRB_ADDR_WAKE_SEL, 32'(s));
			for (int k = 0; k < 3; k++) begin
				partner.set_lines(k == 0, k == 1, k == 2);
				repeat (6) @(negedge sys_clk_i);
				check({31'h0, wake}, {31'h0, (k == 1) || (s == 1 ? k == 2 : k == 0)});
				partner.set_lines(1'h0, 1'h0, 1'h0);
				repeat (6) @(negedge sys_clk_i);
				check({31'h0, wake}, 32'h0);
			end
		end
		// An awake core ignores every wake source
		sleeping = 1'h0;
		partner.set_lines(1'h1, 1'h1, 1'h1);
		repeat (6) @(negedge sys_clk_i);
		check({31'h0, wake}, 32'h0);
		partner.set_lines(1'h0, 1'h0, 1'h0);
		// Reset in mid-run clears select; flag stays clear under an overflow held through reset
		simd_ovf = 1'h1;
		sys_rst_i = 1'h1;
		repeat (3) @(negedge sys_clk_i);
		check({29'h0, pulse, wake, deny}, 32'h0);
		{sys_rst_i, simd_ovf} = 2'h0;
		csr_read(CCSRB_ADDR_WAKE_SEL);
		check(rdata, 32'h0);
		check({31'h0, deny}, 32'h1);
		csr_read(CCSRB_ADDR_SAT_FLAG);
		check(rdata, 32'h0);
		conclude();
	end
endmodule : ccsrb_core_csr_bank_bench
`default_nettype wire
